// ### dv/bit_test_skip_decode_tb.sv
// Self-checking bench for the bit-test-and-skip decoder.
`timescale 1ns/10ps
module bit_test_skip_decode_tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] insn_word = 12'h000;
    logic [7:0]  rd_data;
    logic [4:0]  rd_addr;
    logic        cyc_end, skip, is_clr, is_set;
    logic [11:0] exec_word;
    int          n_mismatch = 0;
    int          num_checks = 0;
    // Each row: tested word, following word, expected skip. Rows 2 and 5 follow with a skip word that must die.
    logic [24:0] rows [6] = '{{12'h623, 12'hABC, 1'b0}, {12'h6E0, 12'h6E0, 1'b1}, {12'h7FF, 12'h123, 1'b1},
                              {12'h700, 12'hABC, 1'b0}, {12'h682, 12'h7FF, 1'b1}, {12'h7E2, 12'h5A5, 1'b0}};
    btsd_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .insn_word(insn_word), .file_rd_data(rd_data),
        .file_rd_addr(rd_addr), .cycle_end(cyc_end), .skip_active(skip), .exec_word(exec_word),
        .is_bit_test_skip_clear(is_clr), .is_bit_test_skip_set(is_set));
    btsd_file_model fm (.file_rd_addr(rd_addr), .file_rd_data(rd_data));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task next_cycle;
        do @(negedge ref_clk); while (cyc_end !== 1'b1);
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(exec_word, 12'h000);
        check({11'h0, skip}, 12'h000);
        next_cycle();
        foreach (rows[i]) begin
            insn_word = rows[i][24:13];
            #1;
            check({11'h0, is_clr}, {11'h0, rows[i][24:21] == 4'h6});
            check({11'h0, is_set}, {11'h0, rows[i][24:21] == 4'h7});
            check({7'h0, rd_addr}, {7'h0, rows[i][17:13]});
            next_cycle();
            check(exec_word, rows[i][24:13]);
            check({11'h0, skip}, {11'h0, rows[i][0]});
            insn_word = rows[i][12:1];
            next_cycle();
            check(exec_word, rows[i][0] ? 12'h000 : rows[i][12:1]);
            check({11'h0, skip}, 12'h000);
        end
        // Mid-run reset with a skipping word waiting: idle state, then a fresh four-clock count.
        insn_word = 12'h6E0;
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(exec_word, 12'h000);
        check({11'h0, skip}, 12'h000);
        repeat (2) @(negedge ref_clk);
        check({11'h0, cyc_end}, 12'h000);
        @(negedge ref_clk);
        check({11'h0, cyc_end}, 12'h001);
        next_cycle();
        check(exec_word, 12'h6E0);
        check({11'h0, skip}, 12'h001);
        tally_and_finish();
    end
    initial begin
        #5000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // bit_test_skip_decode_tb

// ### dv/btsd_file_model.sv
// File register array model behind the read port.
`timescale 1ns/10ps
module btsd_file_model (
    input  wire logic [4:0] file_rd_addr,
    output logic      [7:0] file_rd_data
);
    // Each location holds a pattern built from its address, so bit indexes see both levels.
    assign file_rd_data = {file_rd_addr[2:0], file_rd_addr};
endmodule // btsd_file_model

// ### inc/btsd_pkg.sv
// Package for the bit-test-and-skip decoder: opcodes, field layout and timing.
package btsd_pkg;
    localparam int          INSN_W        = 12;
    localparam int          OPC_HI        = 11;
    localparam int          OPC_LO        = 8;
    localparam int          BIT_HI        = 7;
    localparam int          BIT_LO        = 5;
    localparam int          FILE_HI       = 4;
    localparam int          FILE_LO       = 0;
    localparam logic [3:0]  OPC_SKIP_CLR  = 4'h6;
    localparam logic [3:0]  OPC_SKIP_SET  = 4'h7;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [1:0]  PHASE_RST     = 2'h0;
    localparam logic [11:0] NOP_WORD      = 12'h000;

    typedef struct packed {
        logic [3:0] opcode;
        logic [2:0] bit_sel;
        logic [4:0] file_addr;
    } btsd_insn_s;

    typedef struct packed {
        logic       valid;
        logic       skip;
        logic [4:0] file_addr;
        logic [2:0] bit_sel;
    } btsd_dec_s;
endpackage

// ### rtl/btsd_decoder.sv
// Bit-test-and-skip decode and execute logic for a 12-bit instruction core.
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - Opcode 0110: skip when tested bit clear.
// RULE_02 - Clear skip: drop prefetch, run NOP instead.
// RULE_03 - Opcode 0111: skip when tested bit set.
// RULE_04 - Set skip: drop prefetch, run NOP instead.
// RULE_05 - Condition false: one cycle, next runs normally.
// RULE_06 - File address 0..31, bit index 0..7.
// RULE_07 - Bit index bits 7:5, file bits 4:0.
// RULE_08 - Instruction cycle spans four oscillator periods.
// RULE_09 - No flag, W or file register change.
module btsd_decoder (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic [btsd_pkg::INSN_W-1:0]  insn_word,
    input  wire logic [7:0]                   file_rd_data,
    output logic      [4:0]                   file_rd_addr,
    output logic                              cycle_end,
    output logic                              skip_active,
    output logic      [btsd_pkg::INSN_W-1:0]  exec_word,
    output logic                              is_bit_test_skip_clear,
    output logic                              is_bit_test_skip_set
);
    btsd_pkg::btsd_insn_s insn;
    btsd_pkg::btsd_dec_s  dec;
    logic [1:0]                  phase_r, phase_nxt;
    logic                        skip_r, skip_nxt;
    logic [btsd_pkg::INSN_W-1:0] exec_r, exec_nxt;
    logic                        tested_bit;
    logic [7:0]                  bit_lane;

    // Field extraction follows the bit-oriented format.
    assign insn = btsd_pkg::btsd_insn_s'(insn_word); // RULE_07
    assign is_bit_test_skip_clear = (insn.opcode == btsd_pkg::OPC_SKIP_CLR); // RULE_01
    assign is_bit_test_skip_set   = (insn.opcode == btsd_pkg::OPC_SKIP_SET); // RULE_03
    // Five address bits reach every location 0..31; the index picks one of eight bits.
    assign file_rd_addr = insn.file_addr; // RULE_06
    // One lane per data bit; only the lane whose index matches the operand passes its level.
    for (genvar g = 0; g < 8; g++) begin : g_bit_lane
        assign bit_lane[g] = file_rd_data[g] && (insn.bit_sel == 3'(g)); // RULE_06
    end
    assign tested_bit   = |bit_lane; // RULE_06

    always_comb begin
        dec.valid     = is_bit_test_skip_clear || is_bit_test_skip_set;
        dec.file_addr = insn.file_addr;
        dec.bit_sel   = insn.bit_sel;
        dec.skip      = (is_bit_test_skip_clear && !tested_bit) // RULE_01
                     || (is_bit_test_skip_set && tested_bit); // RULE_03
    end

    // Four ref_clk periods model the four oscillator periods of one cycle.
    assign cycle_end = (phase_r == btsd_pkg::PHASE_LAST); // RULE_08

    always_comb begin
        phase_nxt = phase_r + 2'h1; // RULE_08
        skip_nxt  = skip_r;
        exec_nxt  = exec_r;
        if (cycle_end) begin
            if (skip_r) begin
                // The prefetched word is replaced, so its skip test is never evaluated.
                exec_nxt = btsd_pkg::NOP_WORD; // RULE_02 RULE_04
                skip_nxt = 1'b0;
            end else begin
                exec_nxt = insn_word; // RULE_05
                skip_nxt = !skip_active && dec.valid && dec.skip; // RULE_02 RULE_04 RULE_05
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_r <= btsd_pkg::PHASE_RST;
            skip_r  <= 1'b0;
            exec_r  <= btsd_pkg::NOP_WORD;
        end else begin
            phase_r <= phase_nxt;
            skip_r  <= skip_nxt;
            exec_r  <= exec_nxt;
        end
    end

    // This block has no write path to W, status or the file array at all.
    assign skip_active = skip_r; // RULE_09
    assign exec_word   = exec_r;

    a_skip_clear_nop: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_02
        cycle_end && !skip_r && is_bit_test_skip_clear && !tested_bit
        |=> skip_r ##3 (cycle_end && skip_r) ##1 (exec_word == btsd_pkg::NOP_WORD && !skip_r))
        else $error("Clear skip did not replace next word with NOP.");
    a_skip_set_nop: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_04
        cycle_end && !skip_r && is_bit_test_skip_set && tested_bit
        |=> skip_r ##3 (cycle_end && skip_r) ##1 (exec_word == btsd_pkg::NOP_WORD && !skip_r))
        else $error("Set skip did not replace next word with NOP.");
    a_no_skip_pass: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_05
        cycle_end && !skip_r && is_bit_test_skip_clear && tested_bit
        |=> !skip_r && exec_word == $past(insn_word))
        else $error("Clear test with bit set still skipped.");
    a_set_no_skip: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_05
        cycle_end && !skip_r && is_bit_test_skip_set && !tested_bit
        |=> !skip_r)
        else $error("Set test with bit clear still skipped.");
    a_cycle_four: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_08
        cycle_end |=> !cycle_end [*3] ##1 cycle_end)
        else $error("Instruction cycle is not four clocks.");
    a_exec_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_05
        !cycle_end |=> $stable(exec_word))
        else $error("Executed word changed inside a cycle.");
    a_addr_field: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_07
        file_rd_addr == insn_word[4:0])
        else $error("File address not taken from bits 4:0.");
    a_skip_once: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_02
        $rose(skip_r) |-> skip_r [*4] ##1 !skip_r)
        else $error("Skip lasted other than one cycle.");

    // Reset parks the phase counter and clears any pending skip.
    a_reset_idle: assert property (@(posedge ref_clk) // RULE_08
        sys_rst
        |=> phase_r == btsd_pkg::PHASE_RST && !skip_r && exec_word == btsd_pkg::NOP_WORD)
        else $error("Reset did not return the decoder to idle.");

    // The first instruction boundary after reset comes on the fourth edge.
    a_first_end: assert property (@(posedge ref_clk) // RULE_08
        $fell(sys_rst)
        |-> !cycle_end [*3] ##1 cycle_end)
        else $error("First cycle end after reset misplaced.");

    // The clear flag follows the opcode nibble alone, whatever the operands hold.
    a_clr_decode: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_01
        is_bit_test_skip_clear
        == (insn_word[btsd_pkg::OPC_HI:btsd_pkg::OPC_LO] == btsd_pkg::OPC_SKIP_CLR))
        else $error("Clear opcode decode wrong.");

    // The set flag follows the opcode nibble alone, whatever the operands hold.
    a_set_decode: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_03
        is_bit_test_skip_set
        == (insn_word[btsd_pkg::OPC_HI:btsd_pkg::OPC_LO] == btsd_pkg::OPC_SKIP_SET))
        else $error("Set opcode decode wrong.");

    // A word can never be both tests at once.
    a_decode_excl: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_01
        !(is_bit_test_skip_clear
        && is_bit_test_skip_set))
        else $error("Both test decodes active together.");

    // The lane network must agree with a direct index of the read data.
    a_bit_pick: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_07
        tested_bit
        == file_rd_data[insn_word[btsd_pkg::BIT_HI:btsd_pkg::BIT_LO]])
        else $error("Tested bit not the one selected by bits 7:5.");

    // The decoded operand fields sit where the bit-oriented format puts them.
    a_dec_fields: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_07
        dec.file_addr == insn_word[btsd_pkg::FILE_HI:btsd_pkg::FILE_LO]
        && dec.bit_sel == insn_word[btsd_pkg::BIT_HI:btsd_pkg::BIT_LO])
        else $error("Decoded operand fields misplaced.");

    // A taken clear test still executes itself before the dropped word.
    a_clr_skip_self: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_01
        cycle_end && !skip_r && is_bit_test_skip_clear && !tested_bit
        |=> skip_r && exec_word == $past(insn_word))
        else $error("Clear test with bit clear did not arm the skip.");

    // A taken set test still executes itself before the dropped word.
    a_set_skip_self: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_03
        cycle_end && !skip_r && is_bit_test_skip_set && tested_bit
        |=> skip_r && exec_word == $past(insn_word))
        else $error("Set test with bit set did not arm the skip.");

    // An untaken set test passes the word on and arms nothing.
    a_set_pass_exec: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_05
        cycle_end && !skip_r && is_bit_test_skip_set && !tested_bit
        |=> !skip_r && exec_word == $past(insn_word))
        else $error("Untaken set test did not execute normally.");

    // A dropped word is never decoded, so a skip cannot chain into another.
    a_chain_refused: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_02
        cycle_end && skip_r
        |=> !skip_r && exec_word == btsd_pkg::NOP_WORD)
        else $error("Skip chained or dropped word executed.");

    // Any other instruction runs normally and never arms a skip.
    a_other_no_skip: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_05
        cycle_end && !skip_r && !dec.valid
        |=> !skip_r && exec_word == $past(insn_word))
        else $error("Non-test instruction disturbed program flow.");

    // A skip can only be armed at an instruction boundary.
    a_skip_at_end: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_02
        $rose(skip_r)
        |-> $past(cycle_end))
        else $error("Skip armed inside a cycle.");

    // A skip is only armed by a test whose condition held.
    a_skip_reason: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_03
        $rose(skip_r)
        |-> $past((is_bit_test_skip_clear && !tested_bit) || (is_bit_test_skip_set && tested_bit)))
        else $error("Skip armed without a true test.");

    // The executed word only moves at an instruction boundary.
    a_exec_at_end: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_05
        $changed(exec_word)
        |-> $past(cycle_end))
        else $error("Executed word moved inside a cycle.");

    // The dropped word costs exactly one extra four-clock cycle.
    a_skip_cost: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_08
        $rose(skip_r)
        |-> !cycle_end [*3] ##1 cycle_end)
        else $error("Skip cycle is not four clocks.");

    // The phase counter steps by one inside a cycle.
    a_phase_step: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_08
        !cycle_end
        |=> phase_r == $past(phase_r) + 2'h1)
        else $error("Phase counter did not step by one.");

    // Only the fetched word or a NOP is ever executed; nothing is written back.
    a_exec_source: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_09
        cycle_end
        |=> exec_word == btsd_pkg::NOP_WORD || exec_word == $past(insn_word))
        else $error("Executed word from an unknown source.");
endmodule // btsd_decoder
